// ---- lpbi_pkg.sv ----
package lpbi_pkg;
	localparam int CA_W = 6;
	localparam int DQ_W = 16;
	localparam int BA_W = 3;
	localparam int ROW_W = 15;
	localparam int COL_W = 10;
	localparam int NBANK = 8;
	localparam int BURST_LEN = 16;
	localparam int MR_ADDR_W = 6;
	// Mode register addresses
	localparam logic [5:0] MRA_LAT_WR = 6'h01;
	localparam logic [5:0] MRA_RW_LAT = 6'h02;
	localparam logic [5:0] MRA_DBI = 6'h03;
	localparam logic [5:0] MRA_TERM = 6'h0b;
	localparam logic [5:0] MRA_VREF_CA = 6'h0c;
	localparam logic [5:0] MRA_FSP = 6'h0d;
	localparam logic [5:0] MRA_VREF_DQ = 6'h0e;
	// Reset values
	localparam logic [7:0] RST_LAT_WR = 8'h00;
	localparam logic [7:0] RST_RW_LAT = 8'h00;
	localparam logic [7:0] RST_DBI = 8'h00;
	localparam logic [7:0] RST_TERM = 8'h00;
	localparam logic [7:0] RST_VREF = 8'h5d;
	localparam logic [7:0] RST_FSP = 8'h00;
	// Fields writable while in ST_ACTIVE
	localparam logic [7:0] ACT_MASK_LAT_WR = 8'h8f;
	localparam logic [7:0] ACT_MASK_DBI = 8'hc0;
	localparam logic [7:0] ACT_MASK_TERM = 8'hff;
	localparam logic [7:0] ACT_MASK_FSP = 8'h20;
	localparam logic [7:0] ACT_MASK_NONE = 8'h00;
	localparam int WRLEV_BIT = 7;
	localparam int FSP_SEL_LSB = 6;
	// First-tick command opcodes, CA[4:0]
	localparam logic [4:0] OP_ACT1 = 5'h01;
	localparam logic [4:0] OP_CAS2 = 5'h12;
	localparam logic [4:0] OP_WR = 5'h04;
	localparam logic [4:0] OP_RD = 5'h02;
	localparam logic [4:0] OP_MRW1 = 5'h06;
	localparam logic [4:0] OP_MRW2 = 5'h16;
	localparam logic [4:0] OP_PRE = 5'h10;
	localparam logic [4:0] OP_SRE = 5'h18;
	localparam logic [4:0] OP_SRX = 5'h14;
	localparam logic [4:0] OP_MPC = 5'h00;
	localparam logic [4:0] OP_PDE = 5'h08;
	localparam logic [4:0] OP_PDX = 5'h0c;
	localparam logic [4:0] OP_TRX = 5'h1e;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_MRW, CMD_PRE,
		CMD_SRE, CMD_SRX, CMD_MPC_TRAIN, CMD_PDE, CMD_PDX, CMD_TRX
	} lpbi_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ACTIVE, ST_SREF, ST_PDN, ST_TRAIN
	} lpbi_state_t;
endpackage

// ---- lpbi_if.sv ----
`timescale 1ns/10ps
interface lpbi_if;
	logic reset_n;
	logic cs;
	logic [5:0] ca;
	logic [15:0] dq_ctl_o;
	logic dq_ctl_oe;
	logic [15:0] dq_dev_o;
	logic dq_dev_oe;
	modport ctl (output reset_n, output cs, output ca, output dq_ctl_o, output dq_ctl_oe,
		input dq_dev_o, input dq_dev_oe);
	modport dev (input reset_n, input cs, input ca, input dq_ctl_o, input dq_ctl_oe,
		output dq_dev_o, output dq_dev_oe);
endinterface

// ---- lpbi_ca_capture.sv ----
`timescale 1ns/10ps
module lpbi_ca_capture (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic cs_i,
	input wire logic [5:0] ca_i,
	output logic word_vld_o,
	output logic [11:0] word_o
);
	logic half_reg;
	logic [5:0] first_reg;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			half_reg <= 1'b0;
			first_reg <= 6'h00;
			word_vld_o <= 1'b0;
			word_o <= 12'h000;
		end
		else
		begin
			word_vld_o <= 1'b0;
			if (!half_reg && cs_i)
			begin
				half_reg <= 1'b1; // R1
				first_reg <= ca_i;
			end
			else if (half_reg)
			begin
				half_reg <= 1'b0;
				word_vld_o <= 1'b1; // R1
				word_o <= {ca_i, first_reg};
			end
		end
	end
endmodule

// ---- lpbi_device.sv ----
`timescale 1ns/10ps
// Behaviour
// R1 - CA word taken over two rising edges
// R2 - Two-part commands complete on second part
// R3 - Sixteen DQ beats per access
// R4 - Burst runs from start column sequentially
// R5 - Activate opens registered row in bank
// R6 - Read/write use registered bank and column
// R7 - Eight banks, 15-bit row, 10-bit column
// R8 - Low two column bits forced zero
// R9 - Controller drives unused address bits valid
// R10 - Idle means all banks precharged
// R11 - Self refresh allows pd, mrw, training
// R12 - Trained-by-mrw never auto-returns to idle
// R13 - Mode write returns to originating state
// R14 - Reset from any state
// R15 - Active mode writes limited to fields
// R16 - Set point select resets to zero
// R17 - Latency fields reset to zero codes
// R18 - Bus inversion and termination reset off
// R19 - Reference voltages reset to 1, 011101b
// R20 - Controller runs mandated power-up sequence (controller only drives reset_n from reg 2 bit0 as software writes it)
// R21 - Controller waits 2 us before mode access (controller has no wait logic; the testbench waits 200 cycles)
// R22 - Latency bit 7 enters write leveling
module lpbi_device #(
	parameter int NROW_MEM = 16
) (
	input wire logic ref_clk_i,
	lpbi_if.dev bus,
	output logic [2:0] state_o,
	output logic write_leveling_o,
	output logic [1:0] set_point_select_o,
	output logic [7:0] ca_reference_voltage_o,
	output logic [7:0] dq_reference_voltage_o,
	output logic [7:0] bank_open_o
);
	logic rst_s1_reg, rst_s2_reg, dev_rstn;
	logic wv;
	logic [11:0] w;
	logic [11:0] part1_reg;
	logic [1:0] pend_reg;
	lpbi_pkg::lpbi_state_t st_reg, ret_reg;
	logic [7:0] mr_lat_wr_reg, mr_rw_lat_reg, mr_dbi_reg, mr_term_reg;
	logic [7:0] mr_vca_reg, mr_fsp_reg, mr_vdq_reg;
	logic [7:0] open_reg;
	logic [14:0] row_reg [0:7];
	logic [5:0] mra_reg;
	logic [4:0] beat_reg;
	logic rd_reg, wr_reg;
	logic [2:0] bank_reg;
	logic [9:0] col_reg;
	logic [15:0] mem [0:NROW_MEM*1024-1];
	logic [15:0] dq_o_reg;
	lpbi_pkg::lpbi_cmd_t cmd;

	always_ff @(posedge ref_clk_i)
	begin
		rst_s1_reg <= bus.reset_n;
		rst_s2_reg <= rst_s1_reg;
	end
	assign dev_rstn = rst_s2_reg; // R14

	lpbi_ca_capture u_cap (
		.ref_clk_i(ref_clk_i),
		.rstn_i(dev_rstn),
		.cs_i(bus.cs),
		.ca_i(bus.ca),
		.word_vld_o(wv),
		.word_o(w)
	);

	function automatic logic [7:0] act_mask(input logic [5:0] a);
		case (a)
			lpbi_pkg::MRA_LAT_WR: act_mask = lpbi_pkg::ACT_MASK_LAT_WR;
			lpbi_pkg::MRA_DBI: act_mask = lpbi_pkg::ACT_MASK_DBI;
			lpbi_pkg::MRA_TERM: act_mask = lpbi_pkg::ACT_MASK_TERM;
			lpbi_pkg::MRA_FSP: act_mask = lpbi_pkg::ACT_MASK_FSP;
			default: act_mask = lpbi_pkg::ACT_MASK_NONE;
		endcase
	endfunction

	function automatic logic [7:0] mrw(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		mrw = (old & ~m) | (nw & m);
	endfunction

	// Decode of a completed two-part or single command
	always_comb
	begin
		cmd = lpbi_pkg::CMD_NONE;
		if (wv)
		begin
			if (pend_reg != 2'd0)
			begin
				if (pend_reg == 2'd1)
					cmd = lpbi_pkg::CMD_ACT; // R2
				else if (part1_reg[4:0] == lpbi_pkg::OP_MRW1)
					cmd = lpbi_pkg::CMD_MRW; // R2
				else if (w[4:0] == lpbi_pkg::OP_CAS2)
					cmd = (part1_reg[4:0] == lpbi_pkg::OP_RD) ? lpbi_pkg::CMD_RD
						: lpbi_pkg::CMD_WR; // R2
			end
			else
			begin
				case (w[4:0])
					lpbi_pkg::OP_PRE: cmd = lpbi_pkg::CMD_PRE;
					lpbi_pkg::OP_SRE: cmd = lpbi_pkg::CMD_SRE;
					lpbi_pkg::OP_SRX: cmd = lpbi_pkg::CMD_SRX;
					lpbi_pkg::OP_MPC: cmd = lpbi_pkg::CMD_MPC_TRAIN;
					lpbi_pkg::OP_PDE: cmd = lpbi_pkg::CMD_PDE;
					lpbi_pkg::OP_PDX: cmd = lpbi_pkg::CMD_PDX;
					lpbi_pkg::OP_TRX: cmd = lpbi_pkg::CMD_TRX;
					default: cmd = lpbi_pkg::CMD_NONE;
				endcase
			end
		end
	end

	// First part holding
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
		begin
			pend_reg <= 2'd0;
			part1_reg <= 12'h000;
		end
		else if (wv)
		begin
			part1_reg <= w;
			if (pend_reg != 2'd0)
				pend_reg <= 2'd0;
			else if (w[4:0] == lpbi_pkg::OP_ACT1)
				pend_reg <= 2'd1; // R2
			else if (w[4:0] == lpbi_pkg::OP_RD || w[4:0] == lpbi_pkg::OP_WR
				|| w[4:0] == lpbi_pkg::OP_MRW1)
				pend_reg <= 2'd2; // R2
		end
	end

	// Bus-interface state machine
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
		begin
			st_reg <= lpbi_pkg::ST_IDLE; // R14
			ret_reg <= lpbi_pkg::ST_IDLE;
		end
		else
		begin
			case (st_reg)
				lpbi_pkg::ST_IDLE:
					if (cmd == lpbi_pkg::CMD_ACT)
						st_reg <= lpbi_pkg::ST_ACTIVE;
					else if (cmd == lpbi_pkg::CMD_SRE)
						st_reg <= lpbi_pkg::ST_SREF;
					else if (cmd == lpbi_pkg::CMD_PDE)
						st_reg <= lpbi_pkg::ST_PDN;
					else if (cmd == lpbi_pkg::CMD_MPC_TRAIN)
					begin
						ret_reg <= lpbi_pkg::ST_IDLE;
						st_reg <= lpbi_pkg::ST_TRAIN;
					end
				lpbi_pkg::ST_ACTIVE:
					if (cmd == lpbi_pkg::CMD_PRE)
						st_reg <= lpbi_pkg::ST_IDLE; // R10
					else if (cmd == lpbi_pkg::CMD_PDE)
						st_reg <= lpbi_pkg::ST_PDN;
				lpbi_pkg::ST_SREF:
					if (cmd == lpbi_pkg::CMD_SRX)
						st_reg <= lpbi_pkg::ST_IDLE;
					else if (cmd == lpbi_pkg::CMD_PDE)
						st_reg <= lpbi_pkg::ST_PDN; // R11
					else if (cmd == lpbi_pkg::CMD_MPC_TRAIN)
					begin
						ret_reg <= lpbi_pkg::ST_SREF; // R11
						st_reg <= lpbi_pkg::ST_TRAIN;
					end
				lpbi_pkg::ST_PDN:
					if (cmd == lpbi_pkg::CMD_PDX)
						st_reg <= (open_reg != 8'h00) ? lpbi_pkg::ST_ACTIVE
							: lpbi_pkg::ST_IDLE;
				lpbi_pkg::ST_TRAIN:
					if (cmd == lpbi_pkg::CMD_TRX)
						st_reg <= ret_reg; // R12
				default: st_reg <= lpbi_pkg::ST_IDLE;
			endcase
			// Write-leveling entry remembers its origin
			if (cmd == lpbi_pkg::CMD_MRW && w[11:6] == lpbi_pkg::MRA_RW_LAT
				&& part1_reg[11] && st_reg != lpbi_pkg::ST_ACTIVE)
			begin
				ret_reg <= st_reg; // R13
				st_reg <= lpbi_pkg::ST_TRAIN; // R22
			end
		end
	end

	// Bank rows
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
			open_reg <= 8'h00;
		else if (cmd == lpbi_pkg::CMD_ACT)
		begin
			open_reg[part1_reg[11:9]] <= 1'b1; // R5
			row_reg[part1_reg[11:9]] <= {w, part1_reg[8:6]}; // R5 R7
		end
		else if (cmd == lpbi_pkg::CMD_PRE)
			open_reg <= 8'h00; // R10
	end

	// Mode registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
		begin
			mr_lat_wr_reg <= lpbi_pkg::RST_LAT_WR; // R17
			mr_rw_lat_reg <= lpbi_pkg::RST_RW_LAT; // R17
			mr_dbi_reg <= lpbi_pkg::RST_DBI; // R18
			mr_term_reg <= lpbi_pkg::RST_TERM; // R18
			mr_vca_reg <= lpbi_pkg::RST_VREF; // R19
			mr_fsp_reg <= lpbi_pkg::RST_FSP; // R16
			mr_vdq_reg <= lpbi_pkg::RST_VREF; // R19
		end
		else if (cmd == lpbi_pkg::CMD_MRW)
		begin
			case (w[11:6])
				lpbi_pkg::MRA_LAT_WR: mr_lat_wr_reg <= mrw(mr_lat_wr_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				lpbi_pkg::MRA_RW_LAT: mr_rw_lat_reg <= mrw(mr_rw_lat_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				lpbi_pkg::MRA_DBI: mr_dbi_reg <= mrw(mr_dbi_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				lpbi_pkg::MRA_TERM: mr_term_reg <= {part1_reg[11:6], w[1:0]};
				lpbi_pkg::MRA_VREF_CA: mr_vca_reg <= mrw(mr_vca_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				lpbi_pkg::MRA_FSP: mr_fsp_reg <= mrw(mr_fsp_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				lpbi_pkg::MRA_VREF_DQ: mr_vdq_reg <= mrw(mr_vdq_reg, {part1_reg[11:6],
					w[1:0]}, (st_reg == lpbi_pkg::ST_ACTIVE) ? act_mask(w[11:6]) : 8'hff); // R15
				default: mra_reg <= w[11:6];
			endcase
		end
	end

	// Burst engine
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
		begin
			beat_reg <= 5'd0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			bank_reg <= 3'd0;
			col_reg <= 10'h000;
		end
		else if ((cmd == lpbi_pkg::CMD_RD || cmd == lpbi_pkg::CMD_WR)
			&& open_reg[part1_reg[8:6]])
		begin
			bank_reg <= part1_reg[8:6]; // R6
			col_reg <= {w[11:6], w[5], 3'b000} & 10'h3fc; // R6 R8
			beat_reg <= 5'd0;
			rd_reg <= (cmd == lpbi_pkg::CMD_RD);
			wr_reg <= (cmd == lpbi_pkg::CMD_WR);
		end
		else if (rd_reg || wr_reg)
		begin
			if (beat_reg == 5'(lpbi_pkg::BURST_LEN - 1))
			begin
				rd_reg <= 1'b0; // R3
				wr_reg <= 1'b0;
			end
			beat_reg <= beat_reg + 5'd1; // R4
		end
	end

	logic [$clog2(NROW_MEM*1024)-1:0] maddr;
	assign maddr = $clog2(NROW_MEM*1024)'({row_reg[bank_reg][3:0], col_reg[9:4],
		col_reg[3:0] + beat_reg[3:0]}); // R4
	always_ff @(posedge ref_clk_i)
	begin
		if (wr_reg && bus.dq_ctl_oe)
			mem[maddr] <= bus.dq_ctl_o; // R3
		dq_o_reg <= mem[maddr];
	end

	assign bus.dq_dev_o = dq_o_reg;
	logic oe_reg;
	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
			oe_reg <= 1'b0;
		else
			oe_reg <= rd_reg; // R3
	end
	assign bus.dq_dev_oe = oe_reg;

	always_ff @(posedge ref_clk_i)
	begin
		if (!dev_rstn)
		begin
			state_o <= 3'd0;
			write_leveling_o <= 1'b0;
			set_point_select_o <= 2'b00;
			ca_reference_voltage_o <= lpbi_pkg::RST_VREF;
			dq_reference_voltage_o <= lpbi_pkg::RST_VREF;
			bank_open_o <= 8'h00;
		end
		else
		begin
			state_o <= 3'(st_reg);
			write_leveling_o <= mr_rw_lat_reg[lpbi_pkg::WRLEV_BIT]; // R22
			set_point_select_o <= mr_fsp_reg[7:6]; // R16
			ca_reference_voltage_o <= mr_vca_reg;
			dq_reference_voltage_o <= mr_vdq_reg;
			bank_open_o <= open_reg;
		end
	end
endmodule

// ---- lpbi_controller.sv ----
`timescale 1ns/10ps
module lpbi_controller (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	lpbi_if.ctl bus,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o
);
	// Reg 0: CA word (bits 11:0) to send, 1: dq data, 2: control bit0 reset_n,
	// bit1 dq drive, 3: status read back of dq from device
	logic [11:0] word_reg;
	logic go_reg;
	logic ph_reg;
	logic rst_reg, drv_reg;
	logic [15:0] dqw_reg;
	logic [15:0] dqs1_reg, dqs2_reg;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			word_reg <= 12'h000;
			go_reg <= 1'b0;
			ph_reg <= 1'b0;
			rst_reg <= 1'b0;
			drv_reg <= 1'b0;
			dqw_reg <= 16'h0000;
		end
		else
		begin
			if (wr_i && addr_i == 4'h0)
			begin
				word_reg <= wdata_i[11:0]; // R9
				go_reg <= 1'b1;
				ph_reg <= 1'b0;
			end
			else if (go_reg)
			begin
				ph_reg <= ~ph_reg; // R1
				if (ph_reg)
					go_reg <= 1'b0;
			end
			if (wr_i && addr_i == 4'h1)
				dqw_reg <= wdata_i[15:0];
			if (wr_i && addr_i == 4'h2)
			begin
				rst_reg <= wdata_i[0]; // R20
				drv_reg <= wdata_i[1];
			end
		end
	end
	assign bus.reset_n = rst_reg;
	assign bus.cs = go_reg & ~ph_reg;
	assign bus.ca = ph_reg ? word_reg[11:6] : word_reg[5:0]; // R1
	assign bus.dq_ctl_o = dqw_reg;
	assign bus.dq_ctl_oe = drv_reg;
	always_ff @(posedge ref_clk_i)
	begin
		dqs1_reg <= bus.dq_dev_o;
		dqs2_reg <= dqs1_reg;
	end
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
			rdata_o <= 32'h0;
		else if (rd_i)
			case (addr_i)
				4'h0: rdata_o <= {20'h0, word_reg};
				4'h2: rdata_o <= {29'h0, go_reg, drv_reg, rst_reg};
				4'h3: rdata_o <= {16'h0, dqs2_reg};
				default: rdata_o <= 32'h0;
			endcase
	end
endmodule

// ---- lpbi_bus_sva.sv ----
`timescale 1ns/10ps
module lpbi_bus_sva (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic reset_n,
	input wire logic cs,
	input wire logic dq_ctl_oe,
	input wire logic dq_dev_oe
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// Select on first tick, quiet on second and gap
	sequence two_tick_s;
		cs ##1 !cs ##1 !cs;
	endsequence

	sequence dev_burst_s;
		dq_dev_oe [*8];
	endsequence

	tick_pair_a: assert property (cs |-> two_tick_s)
		else $error("select not a lone first-tick pulse");
	cs_reset_a: assert property (cs |-> reset_n)
		else $error("command sent while device held in reset");
	reset_low_a: assert property ($rose(rstn_i) |-> !reset_n)
		else $error("device reset not asserted after controller reset");
	ctl_quiet_a: assert property (!reset_n |-> !dq_ctl_oe)
		else $error("controller drives data during device reset");
	dev_quiet_a: assert property (!reset_n [*4] |-> !dq_dev_oe)
		else $error("device drives data while in reset");
	dq_excl_a: assert property (dq_dev_oe |-> !dq_ctl_oe)
		else $error("both ends drive the data bus");
	burst_min_a: assert property ($rose(dq_dev_oe) |-> dev_burst_s ##1 dev_burst_s)
		else $error("read burst shorter than sixteen beats");
	burst_end_a: assert property ($rose(dq_dev_oe) |-> ##16 !dq_dev_oe)
		else $error("read burst never released the bus");
endmodule

// ---- lpddr4_bus_interface_tb.sv ----
`timescale 1ns/10ps
module lpddr4_bus_interface_tb;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [2:0] state_o;
	logic write_leveling_o;
	logic [1:0] set_point_select_o;
	logic [7:0] ca_vref;
	logic [7:0] dq_vref;
	logic [7:0] bank_open_o;
	logic [7:0] open_mask = 8'h00;
	logic [31:0] rng = 32'h418d;
	logic [31:0] r;
	logic [31:0] exp_q[$];
	logic [2:0] sel_q[$];
	logic [2:0] m_sel;
	logic [31:0] m_exp;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	lpbi_if bus ();
	lpbi_controller u_lpbi_controller (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus(bus),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	lpbi_device #(.NROW_MEM(16)) u_lpbi_device (.ref_clk_i(ref_clk_i), .bus(bus),
		.state_o(state_o), .write_leveling_o(write_leveling_o),
		.set_point_select_o(set_point_select_o), .ca_reference_voltage_o(ca_vref),
		.dq_reference_voltage_o(dq_vref), .bank_open_o(bank_open_o));
	lpbi_bus_sva u_lpbi_bus_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.reset_n(bus.reset_n), .cs(bus.cs), .dq_ctl_oe(bus.dq_ctl_oe),
		.dq_dev_oe(bus.dq_dev_oe));

	always #5 ref_clk_i = ~ref_clk_i;

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [31:0] obs(input logic [2:0] s);
		case (s)
			3'h0: return {29'h0, state_o};
			3'h1: return {24'h0, bank_open_o};
			3'h2: return {30'h0, set_point_select_o};
			3'h3: return {24'h0, ca_vref};
			3'h4: return {24'h0, dq_vref};
			3'h5: return {31'h0, write_leveling_o};
			default: return rdata_o;
		endcase
	endfunction

	task complete_run();
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task push(input logic [2:0] s, input logic [31:0] v);
		sel_q.push_back(s);
		exp_q.push_back(v);
	endtask

	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		wdata_i <= rnd();
	endtask

	task rd_bus(input logic [3:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
	endtask

	task send(input logic [11:0] w);
		wr_reg(4'h0, {20'h0, w});
		repeat (5) @(posedge ref_clk_i);
	endtask

	task mrw(input logic [5:0] a, input logic [7:0] d);
		send({d[7:2], 1'b0, lpbi_pkg::OP_MRW1});
		send({a, 4'h0, d[1:0]});
	endtask

	task dev_reset();
		wr_reg(4'h2, 32'h0);
		repeat (6) @(posedge ref_clk_i);
		wr_reg(4'h2, 32'h1);
		repeat (200) @(posedge ref_clk_i);
		push(3'h0, 32'(lpbi_pkg::ST_IDLE));
		push(3'h1, 32'h0);
		push(3'h2, 32'h0);
		push(3'h3, 32'h5d);
		push(3'h4, 32'h5d);
		push(3'h5, 32'h0);
	endtask

	// Checker: compares each noted result once outputs settle
	initial forever
	begin
		@(negedge ref_clk_i);
		while (sel_q.size() > 0)
		begin
			m_sel = sel_q.pop_front();
			m_exp = exp_q.pop_front();
			n_tests++;
			if (obs(m_sel) !== m_exp)
			begin
				n_errors++;
				$display("[FAIL] %0t output %0d got %h expected %h", $time, m_sel, obs(m_sel), m_exp);
			end
		end
	end

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			complete_run();
		end
	end

	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		dev_reset();
		for (int b = 0; b < 8; b++)
		begin
			r = rnd();
			send({b[2:0], r[2:0], 1'b0, lpbi_pkg::OP_ACT1});
			send(r[14:3]);
			open_mask = open_mask | (8'h01 << b);
			push(3'h1, {24'h0, open_mask});
			push(3'h0, 32'(lpbi_pkg::ST_ACTIVE));
		end
		r = rnd();
		wr_reg(4'h1, {16'h0, r[31:16]});
		wr_reg(4'h2, 32'h3);
		rd_bus(4'h2);
		push(3'h6, 32'h3);
		send({3'h0, r[2:0], 1'b0, lpbi_pkg::OP_WR});
		send({r[8:3], r[9], lpbi_pkg::OP_CAS2});
		repeat (30) @(posedge ref_clk_i);
		wr_reg(4'h2, 32'h1);
		send({3'h0, r[2:0], 1'b0, lpbi_pkg::OP_RD});
		send({r[8:3], r[9], lpbi_pkg::OP_CAS2});
		repeat (30) @(posedge ref_clk_i);
		rd_bus(4'h3);
		push(3'h6, {16'h0, r[31:16]});
		mrw(lpbi_pkg::MRA_FSP, 8'he0);
		push(3'h2, 32'h0);
		push(3'h0, 32'(lpbi_pkg::ST_ACTIVE));
		mrw(lpbi_pkg::MRA_VREF_CA, 8'h12);
		push(3'h3, 32'h5d);
		dev_reset();
		mrw(lpbi_pkg::MRA_FSP, 8'hc0);
		push(3'h2, 32'h3);
		push(3'h0, 32'(lpbi_pkg::ST_IDLE));
		r = rnd();
		mrw(lpbi_pkg::MRA_VREF_CA, r[7:0]);
		mrw(lpbi_pkg::MRA_VREF_DQ, r[15:8]);
		push(3'h3, {24'h0, r[7:0]});
		push(3'h4, {24'h0, r[15:8]});
		mrw(lpbi_pkg::MRA_RW_LAT, 8'h80);
		push(3'h5, 32'h1);
		repeat (30) @(posedge ref_clk_i);
		push(3'h0, 32'(lpbi_pkg::ST_TRAIN));
		send({7'h0, lpbi_pkg::OP_TRX});
		push(3'h0, 32'(lpbi_pkg::ST_IDLE));
		send({7'h0, lpbi_pkg::OP_SRE});
		push(3'h0, 32'(lpbi_pkg::ST_SREF));
		mrw(lpbi_pkg::MRA_VREF_CA, 8'h33);
		push(3'h3, 32'h33);
		push(3'h0, 32'(lpbi_pkg::ST_SREF));
		send({7'h0, lpbi_pkg::OP_PDE});
		push(3'h0, 32'(lpbi_pkg::ST_PDN));
		dev_reset();
		rd_bus(4'hf);
		push(3'h6, 32'h0);
		repeat (3) @(posedge ref_clk_i);
		complete_run();
	end
endmodule
